// [src/host_isa_bridge.sv]
// Bridge between the host bus and the expansion bus
//
// Overview of operation
// R1: Target for host cycles; non-preemptable master for DMA transfers.
// R2: Claim hits in memory/IO windows positively; subtractively claim unclaimed accesses.
// R3: Generate parity on driven phases, check parity on received phases; master read data (mst_rdata_i) is taken without a parity check.
// R4: Configuration space reached only via host-issued configuration cycles.
// R5: Out of reset, forward all unclaimed memory and IO cycles to expansion bus.
// R6: Inputs stop forwarding unclaimed IO, memory, or both.
// R7: Default mode covers full range but accepts no expansion bus masters.
// R8: Default mode shares address and data; external latch holds low 16 bits.
// R9: Address latch strobe pulses while the shared bus holds the address.
// R10: Default mode drives top four address bits on general purpose pins 7..4.
// R11: Master mode needs no glue; panel and TV outputs become unavailable.
// R12: Expansion master cycles go to host only for memory; IO stays local.
// R13: Host grant must arrive before any master cycle is driven.
// R14: Channel ready low stretches the expansion cycle until it returns.
// R15: Expansion masters are granted through a cascade-programmed DMA channel.
// R16: Decode boot ROM up to 16 MB; drive ROM and keyboard selects.
// R17: Expansion bus clock is the host clock divided by a programmable divider.
// R18: Software changes mode or decode settings only while the bus is quiet.
`timescale 1ns/100ps
`include "bridge_consts.svh"

module host_isa_bridge #(
   parameter logic [31:0] DEV_VENDOR_ID = `DEV_VENDOR_ID // Arbitrary identity value
) (
   input  wire logic                 clk_i,
   input  wire logic                 nrst_i,
   input  wire bridge_pkg::host_req_t pci_req_i,
   input  wire logic                 idsel_i,
   input  wire logic                 other_claim_i,
   output bridge_pkg::host_rsp_t     pci_rsp_o,
   input  wire logic                 gnt_i,
   input  wire logic                 tgt_done_i,
   input  wire logic [31:0]          mst_rdata_i,
   output bridge_pkg::host_mst_t     mst_o,
   input  wire bridge_pkg::xfer_t    dma_xfer_i,
   input  wire bridge_pkg::xfer_t    isa_mst_i,
   output logic                      xfer_done_o,
   output logic [31:0]               xfer_rdata_o,
   input  wire logic [31:0]          io_base_i,
   input  wire logic [31:0]          io_mask_i,
   input  wire logic [31:0]          mem_base_i,
   input  wire logic [31:0]          mem_mask_i,
   input  wire logic [23:0]          rom_lo_mask_i,
   input  wire logic                 sub_io_dis_i,
   input  wire logic                 sub_mem_dis_i,
   input  wire logic                 master_mode_i,
   input  wire logic                 cascade_en_i,
   input  wire logic                 dreq_i,
   input  wire logic [2:0]           isa_div_i,
   input  wire logic                 iochrdy_i,
   input  wire logic [15:0]          isa_sd_i,
   output bridge_pkg::isa_bus_t      isa_o,
   output logic [3:0]                gpio_hi_o,
   output logic                      gpio_hi_oe_o,
   output logic [3:0]                la_hi_o,
   output logic                      dack_n_o,
   output logic                      panel_en_o,
   output logic                      expansion_bus_clock_o
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic par_of(input logic [31:0] d, input logic [3:0] c);
      par_of = ^{d, c};
   endfunction

   function automatic logic win_hit(input logic [31:0] a, input logic [31:0] b, input logic [31:0] m);
      win_hit = ((a & m) == (b & m));
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   bridge_pkg::state_t    state_ff,   nxt_state;
   logic [1:0]            wait_ff,    nxt_wait;
   logic [1:0]            ticks_ff,   nxt_ticks;
   bridge_pkg::host_req_t req_ff,     nxt_req;
   bridge_pkg::host_rsp_t rsp_ff,     nxt_rsp;
   bridge_pkg::isa_bus_t  isa_ff,     nxt_isa;
   bridge_pkg::host_mst_t mst_ff,     nxt_mst;
   bridge_pkg::xfer_t     xfer_ff,    nxt_xfer;
   logic [3:0]            gpio_hi_ff, nxt_gpio_hi;
   logic                  gpio_oe_ff, nxt_gpio_oe;
   logic [3:0]            la_hi_ff,   nxt_la_hi;
   logic                  done_ff,    nxt_done;
   logic [31:0]           xrdata_ff,  nxt_xrdata;
   logic                  src_isa_ff, nxt_src_isa;
   logic                  dack_n_ff;
   logic                  panel_en_ff;
   logic                  tick;

   isa_clk_div u_div (
      .clk_i                 (clk_i),
      .nrst_i                (nrst_i),
      .div_code_i            (isa_div_i),
      .expansion_bus_clock_o (expansion_bus_clock_o),
      .tick_o                (tick)
   );

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire [3:0]  in_cmd    = pci_req_i.cmd;
   wire [31:0] in_addr   = pci_req_i.addr;
   wire        in_io     = (in_cmd[3:1] == 3'h1);
   wire        in_mem    = (in_cmd[3:1] == 3'h3);
   wire        in_cfg    = (in_cmd[3:1] == 3'h5) && idsel_i;                       // R4
   wire        rom_hit   = in_mem && (in_addr[31:24] == `ROM_TOP_BYTE)
                           && ((in_addr[23:0] & rom_lo_mask_i) == rom_lo_mask_i);   // R16
   wire        kbd_hit   = in_io && ((in_addr[15:0] & `KBD_IO_MASK) == `KBD_IO_ADDR); // R16
   wire        pos_hit   = (in_io && win_hit(in_addr, io_base_i, io_mask_i))
                           || (in_mem && win_hit(in_addr, mem_base_i, mem_mask_i))
                           || rom_hit || kbd_hit;                                  // R2
   wire        sub_ok    = (in_io && !sub_io_dis_i) || (in_mem && !sub_mem_dis_i); // R5 R6
   wire        addr_bad  = par_of(in_addr, in_cmd) != pci_req_i.par_addr;          // R3
   wire        data_bad  = par_of(pci_req_i.wdata, pci_req_i.be_n) != pci_req_i.par_data;
   wire        in_write  = in_cmd[0];
   wire [31:0] cfg_rdata = in_write ? 32'h0 : DEV_VENDOR_ID;
   wire        isa_mst_ok = master_mode_i && !dack_n_ff && isa_mst_i.valid
                            && isa_mst_i.is_mem;                                   // R7 R12
   wire        lim_mode  = !master_mode_i;
   wire        r_mem     = (req_ff.cmd[3:1] == 3'h3);
   wire        r_wr      = req_ff.cmd[0];
   wire [3:0]  mst_cmd   = xfer_ff.write ? `CMD_MEM_WR : `CMD_MEM_RD;
   wire        nxt_dack_n = !(master_mode_i && cascade_en_i && dreq_i);            // R15

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      nxt_state   = state_ff;
      nxt_wait    = wait_ff;
      nxt_ticks   = ticks_ff;
      nxt_req     = req_ff;
      nxt_rsp     = rsp_ff;
      nxt_rsp.done = 1'b0;
      nxt_rsp.perr = 1'b0;
      nxt_isa     = isa_ff;
      nxt_mst     = mst_ff;
      nxt_xfer    = xfer_ff;
      nxt_gpio_hi = gpio_hi_ff;
      nxt_gpio_oe = gpio_oe_ff;
      nxt_la_hi   = la_hi_ff;
      nxt_done    = 1'b0;
      nxt_xrdata  = xrdata_ff;
      nxt_src_isa = src_isa_ff;
      case (state_ff)
         bridge_pkg::ST_IDLE: begin
            nxt_rsp.pos_claim = 1'b0;
            nxt_rsp.sub_claim = 1'b0;
            if (pci_req_i.valid) begin                                            // R1
               nxt_req      = pci_req_i;
               nxt_wait     = 2'h0;
               nxt_ticks    = 2'h0;
               nxt_rsp.perr = addr_bad || (in_write && data_bad);                 // R3
               nxt_isa.rom_cs_n = !rom_hit;
               nxt_isa.kbd_cs_n = !kbd_hit;
               if (in_cfg) begin
                  nxt_rsp.pos_claim = 1'b1;
                  nxt_rsp.done      = 1'b1;
                  nxt_rsp.rdata     = cfg_rdata;
                  nxt_rsp.par       = par_of(cfg_rdata, pci_req_i.be_n);          // R3
               end else if (pos_hit) begin
                  nxt_rsp.pos_claim = 1'b1;                                       // R2
                  nxt_state         = bridge_pkg::ST_ISA_ADDR;
               end else if (sub_ok) begin
                  nxt_state = bridge_pkg::ST_DECODE;
               end
            end else if (dma_xfer_i.valid) begin
               nxt_xfer    = dma_xfer_i;
               nxt_src_isa = 1'b0;
               nxt_mst.req = 1'b1;
               nxt_state   = bridge_pkg::ST_MST_REQ;
            end else if (isa_mst_ok) begin                                        // R12
               nxt_xfer    = isa_mst_i;
               nxt_src_isa = 1'b1;
               nxt_mst.req = 1'b1;
               nxt_state   = bridge_pkg::ST_MST_REQ;
            end
         end
         bridge_pkg::ST_DECODE: begin
            // Slow decode: give every positive decoder its full window first
            if (other_claim_i) begin
               nxt_state = bridge_pkg::ST_IDLE;
            end else if (wait_ff == `SUB_DECODE_CYC - 2'h1) begin
               nxt_rsp.sub_claim = 1'b1;                                          // R2 R5
               nxt_state         = bridge_pkg::ST_ISA_ADDR;
            end else begin
               nxt_wait = wait_ff + 2'h1;
            end
         end
         bridge_pkg::ST_ISA_ADDR: begin
            if (tick && ticks_ff == 2'h0) begin
               nxt_isa.address_latch_strobe = lim_mode;                           // R9
               nxt_isa.sd    = req_ff.addr[15:0];                                 // R8
               nxt_isa.sd_oe = lim_mode;
               nxt_isa.sa    = master_mode_i ? req_ff.addr[15:0] : 16'h0;
               nxt_gpio_hi   = req_ff.addr[23:20];                                // R10
               nxt_gpio_oe   = lim_mode;
               nxt_la_hi     = req_ff.addr[23:20];
               nxt_ticks     = 2'h1;
            end else if (tick) begin
               nxt_isa.address_latch_strobe = 1'b0;
               nxt_isa.sd    = req_ff.wdata[15:0];
               nxt_isa.sd_oe = r_wr;
               nxt_isa.memr_n = !(r_mem && !r_wr);
               nxt_isa.memw_n = !(r_mem && r_wr);
               nxt_isa.ior_n  = !(!r_mem && !r_wr);
               nxt_isa.iow_n  = !(!r_mem && r_wr);
               nxt_ticks      = 2'h0;
               nxt_state      = bridge_pkg::ST_ISA_CMD;
            end
         end
         bridge_pkg::ST_ISA_CMD: begin
            if (tick && ticks_ff != `ISA_CMD_TICKS - 2'h1) begin
               nxt_ticks = ticks_ff + 2'h1;
            end else if (tick && iochrdy_i) begin                                 // R14
               nxt_isa       = `ISA_BUS_IDLE;
               nxt_gpio_oe   = 1'b0;
               nxt_rsp.done  = 1'b1;
               nxt_rsp.rdata = {16'h0, isa_sd_i};
               nxt_rsp.par   = par_of({16'h0, isa_sd_i}, req_ff.be_n);            // R3
               nxt_state     = bridge_pkg::ST_IDLE;
            end
         end
         bridge_pkg::ST_MST_REQ: begin
            if (gnt_i) begin                                                      // R13
               nxt_mst.frame = 1'b1;
               nxt_mst.cmd   = mst_cmd;
               nxt_mst.addr  = xfer_ff.addr;
               nxt_mst.data  = xfer_ff.data;
               nxt_mst.par   = par_of(xfer_ff.addr, mst_cmd);                     // R3
               nxt_state     = bridge_pkg::ST_MST_DATA;
            end
         end
         bridge_pkg::ST_MST_DATA: begin
            // Grant removal is ignored here: the transfer is not preemptable
            nxt_mst.par = par_of(xfer_ff.data, 4'h0);
            if (tgt_done_i) begin                                                 // R1
               nxt_mst.frame = 1'b0;
               nxt_mst.req   = 1'b0;
               nxt_done      = 1'b1;
               nxt_xrdata    = mst_rdata_i;
               nxt_state     = bridge_pkg::ST_IDLE;
            end
         end
         default: nxt_state = bridge_pkg::ST_IDLE;
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_ff    <= bridge_pkg::ST_IDLE;
         wait_ff     <= 2'h0;
         ticks_ff    <= 2'h0;
         req_ff      <= '0;
         rsp_ff      <= '0;
         isa_ff      <= `ISA_BUS_IDLE;
         mst_ff      <= '0;
         xfer_ff     <= '0;
         gpio_hi_ff  <= 4'h0;
         gpio_oe_ff  <= 1'b0;
         la_hi_ff    <= 4'h0;
         done_ff     <= 1'b0;
         xrdata_ff   <= 32'h0;
         src_isa_ff  <= 1'b0;
         dack_n_ff   <= 1'b1;
         panel_en_ff <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         wait_ff     <= nxt_wait;
         ticks_ff    <= nxt_ticks;
         req_ff      <= nxt_req;
         rsp_ff      <= nxt_rsp;
         isa_ff      <= nxt_isa;
         mst_ff      <= nxt_mst;
         xfer_ff     <= nxt_xfer;
         gpio_hi_ff  <= nxt_gpio_hi;
         gpio_oe_ff  <= nxt_gpio_oe;
         la_hi_ff    <= nxt_la_hi;
         done_ff     <= nxt_done;
         xrdata_ff   <= nxt_xrdata;
         src_isa_ff  <= nxt_src_isa;
         dack_n_ff   <= nxt_dack_n;                                               // R15
         panel_en_ff <= lim_mode;                                                 // R11
      end
   end

   assign pci_rsp_o    = rsp_ff;
   assign mst_o        = mst_ff;
   assign isa_o        = isa_ff;
   assign gpio_hi_o    = gpio_hi_ff;
   assign gpio_hi_oe_o = gpio_oe_ff;
   assign la_hi_o      = la_hi_ff;
   assign xfer_done_o  = done_ff;
   assign xfer_rdata_o = xrdata_ff;
   assign dack_n_o     = dack_n_ff;
   assign panel_en_o   = panel_en_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_sub_io_block: assert property (@(posedge clk_i) disable iff (!nrst_i) // R6
      $rose(rsp_ff.sub_claim) |-> !(req_ff.cmd[3:1] == 3'h1 && sub_io_dis_i))
      else $error("unclaimed io forwarded while disabled");
   a_sub_mem_wait: assert property (@(posedge clk_i) disable iff (!nrst_i) // R5
      $rose(rsp_ff.sub_claim) |-> $past(state_ff, 3) == bridge_pkg::ST_DECODE && !(r_mem && sub_mem_dis_i))
      else $error("subtractive claim early or memory disabled");
   a_latch_addr: assert property (@(posedge clk_i) disable iff (!nrst_i) // R9
      isa_ff.address_latch_strobe |-> lim_mode && isa_ff.sd_oe && isa_ff.sd == req_ff.addr[15:0])
      else $error("latch strobe without address on shared bus");
   a_gpio_upper: assert property (@(posedge clk_i) disable iff (!nrst_i) // R10
      gpio_oe_ff && state_ff == bridge_pkg::ST_ISA_CMD |-> gpio_hi_ff == req_ff.addr[23:20])
      else $error("upper address wrong on general purpose pins");
   a_ready_stretch: assert property (@(posedge clk_i) disable iff (!nrst_i) // R14
      state_ff == bridge_pkg::ST_ISA_CMD && tick && !iochrdy_i |=> !rsp_ff.done && !isa_ff.ior_n == $past(!isa_ff.ior_n))
      else $error("cycle ended while channel not ready");
   a_grant_first: assert property (@(posedge clk_i) disable iff (!nrst_i) // R13
      $rose(mst_ff.frame) |-> $past(gnt_i) && $past(mst_ff.req))
      else $error("master cycle without grant");
   a_no_preempt: assert property (@(posedge clk_i) disable iff (!nrst_i) // R1
      mst_ff.frame && !tgt_done_i |=> mst_ff.frame)
      else $error("master transfer preempted");
   a_isa_mem_only: assert property (@(posedge clk_i) disable iff (!nrst_i) // R12
      state_ff == bridge_pkg::ST_MST_REQ && src_isa_ff |-> xfer_ff.is_mem && master_mode_i)
      else $error("expansion io cycle forwarded to host");
   a_addr_parity: assert property (@(posedge clk_i) disable iff (!nrst_i) // R3
      state_ff == bridge_pkg::ST_IDLE && pci_req_i.valid && addr_bad |=> rsp_ff.perr)
      else $error("address parity error not reported");

endmodule // host_isa_bridge

// [src/bridge_consts.svh]
// Constants for the host-bus to expansion-bus bridge
`ifndef BRIDGE_CONSTS_SVH
`define BRIDGE_CONSTS_SVH

// ----------------------------------------
// Host bus command codes
// ----------------------------------------
`define CMD_IO_RD       4'h2
`define CMD_IO_WR       4'h3
`define CMD_MEM_RD      4'h6
`define CMD_MEM_WR      4'h7
`define CMD_CFG_RD      4'ha
`define CMD_CFG_WR      4'hb

// ----------------------------------------
// Decode and timing counts
// ----------------------------------------
`define SUB_DECODE_CYC  2'h3
`define ISA_CMD_TICKS   2'h3
`define ISA_DIV_OFFSET  4'h2
`define KBD_IO_ADDR     16'h0060
`define KBD_IO_MASK     16'hfffb
`define ROM_TOP_BYTE    8'hff

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ISA_BUS_IDLE    40'h000000003f
`define DEV_VENDOR_ID   32'h5a5a1234

`endif

// [src/bridge_pkg.sv]
// Types shared by the bridge modules
package bridge_pkg;

   // ----------------------------------------
   // Host bus carriers
   // ----------------------------------------
   typedef struct packed {
      logic        valid;
      logic [3:0]  cmd;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0]  be_n;
      logic        par_addr;
      logic        par_data;
   } host_req_t;

   typedef struct packed {
      logic        done;
      logic        pos_claim;
      logic        sub_claim;
      logic [31:0] rdata;
      logic        par;
      logic        perr;
   } host_rsp_t;

   typedef struct packed {
      logic        req;
      logic        frame;
      logic [3:0]  cmd;
      logic [31:0] addr;
      logic [31:0] data;
      logic        par;
   } host_mst_t;

   typedef struct packed {
      logic        valid;
      logic        is_mem;
      logic        write;
      logic [31:0] addr;
      logic [31:0] data;
   } xfer_t;

   // ----------------------------------------
   // Expansion bus carrier
   // ----------------------------------------
   typedef struct packed {
      logic        address_latch_strobe;
      logic [15:0] sd;
      logic        sd_oe;
      logic [15:0] sa;
      logic        memr_n;
      logic        memw_n;
      logic        ior_n;
      logic        iow_n;
      logic        rom_cs_n;
      logic        kbd_cs_n;
   } isa_bus_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_DECODE, ST_ISA_ADDR, ST_ISA_CMD, ST_MST_REQ, ST_MST_DATA
   } state_t;

endpackage

// [src/isa_clk_div.sv]
// Expansion bus clock divider with a one-cycle tick enable
`timescale 1ns/100ps
`include "bridge_consts.svh"

module isa_clk_div (
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic [2:0] div_code_i,
   output logic            expansion_bus_clock_o,
   output logic            tick_o
);
   logic [3:0] cnt_ff;
   logic [3:0] divisor;
   logic       last;

   // Offset keeps the divisor at two or more, so ticks never merge
   assign divisor = {1'b0, div_code_i} + `ISA_DIV_OFFSET;
   assign last    = (cnt_ff >= divisor - 4'h1);

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_ff                <= 4'h0;
         tick_o                <= 1'b0;
         expansion_bus_clock_o <= 1'b0;
      end else begin
         cnt_ff                <= last ? 4'h0 : cnt_ff + 4'h1;
         tick_o                <= last;                                  // R17
         expansion_bus_clock_o <= last || (cnt_ff < (divisor >> 1) - 4'h1);
      end
   end

   a_tick_spacing: assert property (@(posedge clk_i) disable iff (!nrst_i)
      tick_o |=> !tick_o) else $error("divider tick lasted two cycles"); // R17

endmodule // isa_clk_div

// [verification/far_side_model.sv]
// Far-side model: expansion bus peripheral plus host arbiter and host target
`timescale 1ns/100ps

module far_side_model (
   input  wire logic                  clk_i,
   input  wire logic                  nrst_i,
   input  wire bridge_pkg::isa_bus_t  isa_i,
   input  wire bridge_pkg::host_mst_t mst_i,
   input  wire logic [3:0]            stretch_i,
   output logic                       iochrdy_o,
   output logic [15:0]                sd_o,
   output logic                       gnt_o,
   output logic                       tgt_done_o,
   output logic [31:0]                rdata_o
);
   logic [15:0] lat_ff;
   logic [3:0]  wait_ff;
   logic        frame_ff;
   wire         rd_act  = !isa_i.ior_n || !isa_i.memr_n;
   wire         cmd_act = rd_act || !isa_i.iow_n || !isa_i.memw_n;

   // Released data bus shows the inverse so a stale value never matches
   assign sd_o      = rd_act ? (lat_ff ^ 16'h5a5a) : ~(lat_ff ^ 16'h5a5a);
   assign iochrdy_o = !cmd_act || (wait_ff == 4'h0);
   assign rdata_o   = ~mst_i.addr;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lat_ff     <= 16'h0000;
         wait_ff    <= 4'h0;
         frame_ff   <= 1'b0;
         gnt_o      <= 1'b0;
         tgt_done_o <= 1'b0;
      end else begin
         if (isa_i.address_latch_strobe) lat_ff <= isa_i.sd;
         wait_ff    <= !cmd_act ? stretch_i : (wait_ff - (wait_ff != 4'h0));
         gnt_o      <= mst_i.req;
         frame_ff   <= mst_i.frame;
         tgt_done_o <= mst_i.frame && !frame_ff;
      end
   end
endmodule // far_side_model

// [verification/tb_host_isa_bridge.sv]
// Self-checking bench for the host to expansion bus bridge
`timescale 1ns/100ps
`include "bridge_consts.svh"

module tb_host_isa_bridge;
   logic clk_i, nrst_i, idsel_i, other_claim_i, sub_io_dis_i, sub_mem_dis_i;
   logic master_mode_i, cascade_en_i, dreq_i, gnt_i, tgt_done_i, iochrdy_i;
   logic xfer_done_o, gpio_hi_oe_o, dack_n_o, panel_en_o, expansion_bus_clock_o;
   logic [31:0] mst_rdata_i, xfer_rdata_o, io_base_i, io_mask_i, mem_base_i, mem_mask_i;
   logic [23:0] rom_lo_mask_i;
   logic [15:0] isa_sd_i;
   logic [3:0]  gpio_hi_o, la_hi_o, stretch, s_gpio;
   logic [2:0]  isa_div_i;
   logic        s_done, s_pos, s_sub, s_perr, s_rom, s_kbd, s_stb, s_req, s_bad;
   logic [31:0] s_rdata;
   int          s_len, miscompares, compares, cycles, n;
   bridge_pkg::host_req_t pci_req_i;
   bridge_pkg::host_rsp_t pci_rsp_o;
   bridge_pkg::host_mst_t mst_o;
   bridge_pkg::xfer_t     dma_xfer_i, isa_mst_i;
   bridge_pkg::isa_bus_t  isa_o;

   host_isa_bridge #(.DEV_VENDOR_ID(32'h1357_9bdf)) u_host_isa_bridge ( // Arbitrary identity value
      .clk_i(clk_i), .nrst_i(nrst_i), .pci_req_i(pci_req_i), .idsel_i(idsel_i), .other_claim_i(other_claim_i),
      .pci_rsp_o(pci_rsp_o), .gnt_i(gnt_i), .tgt_done_i(tgt_done_i), .mst_rdata_i(mst_rdata_i), .mst_o(mst_o),
      .dma_xfer_i(dma_xfer_i), .isa_mst_i(isa_mst_i), .xfer_done_o(xfer_done_o), .xfer_rdata_o(xfer_rdata_o),
      .io_base_i(io_base_i), .io_mask_i(io_mask_i), .mem_base_i(mem_base_i), .mem_mask_i(mem_mask_i),
      .rom_lo_mask_i(rom_lo_mask_i), .sub_io_dis_i(sub_io_dis_i), .sub_mem_dis_i(sub_mem_dis_i),
      .master_mode_i(master_mode_i), .cascade_en_i(cascade_en_i), .dreq_i(dreq_i), .isa_div_i(isa_div_i),
      .iochrdy_i(iochrdy_i), .isa_sd_i(isa_sd_i), .isa_o(isa_o), .gpio_hi_o(gpio_hi_o),
      .gpio_hi_oe_o(gpio_hi_oe_o), .la_hi_o(la_hi_o), .dack_n_o(dack_n_o), .panel_en_o(panel_en_o),
      .expansion_bus_clock_o(expansion_bus_clock_o));

   far_side_model u_far_side_model (
      .clk_i(clk_i), .nrst_i(nrst_i), .isa_i(isa_o), .mst_i(mst_o), .stretch_i(stretch), .iochrdy_o(iochrdy_i),
      .sd_o(isa_sd_i), .gnt_o(gnt_i), .tgt_done_o(tgt_done_i), .rdata_o(mst_rdata_i));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic give_verdict;
      if (miscompares == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One target request held for one cycle, then watched until done or for at most 80 cycles
   task automatic tgt(input logic [3:0] cmd, input logic [31:0] addr, input logic bad);
      @(negedge clk_i);
      pci_req_i = '{1'b1, cmd, addr, 32'h0, 4'h0, (^{addr, cmd}) ^ bad, 1'b0};
      {s_done, s_pos, s_sub, s_perr, s_rom, s_kbd, s_stb, s_len} = '0;
      for (n = 0; n < 80 && !s_done; n++) begin
         @(negedge clk_i);
         pci_req_i.valid = 1'b0;
         s_pos |= pci_rsp_o.pos_claim;
         s_sub |= pci_rsp_o.sub_claim;
         s_perr |= pci_rsp_o.perr;
         s_rom |= !isa_o.rom_cs_n;
         s_kbd |= !isa_o.kbd_cs_n;
         s_len += int'(!isa_o.ior_n || !isa_o.memr_n);
         if (isa_o.address_latch_strobe && isa_o.sd_oe && gpio_hi_oe_o) begin
            s_stb = 1'b1;
            s_gpio = gpio_hi_o;
         end
         s_done = pci_rsp_o.done;
         s_rdata = pci_rsp_o.rdata;
      end
   endtask

   // A master request from the DMA engine or an expansion master, held until done or for at most 40 cycles
   task automatic xfer(input logic from_isa, input logic is_mem, input logic [31:0] addr);
      @(negedge clk_i);
      if (from_isa) isa_mst_i = '{1'b1, is_mem, 1'b0, addr, 32'h0};
      else dma_xfer_i = '{1'b1, is_mem, 1'b0, addr, 32'h0};
      {s_done, s_req, s_bad, s_rdata} = '0;
      for (n = 0; n < 40 && !s_done; n++) begin
         @(posedge clk_i);
         #1;
         s_req |= mst_o.req;
         s_bad |= mst_o.frame && (mst_o.cmd !== `CMD_MEM_RD);
         s_done = xfer_done_o;
         s_rdata = xfer_rdata_o;
      end
      @(negedge clk_i);
      isa_mst_i.valid = 1'b0;
      dma_xfer_i.valid = 1'b0;
   endtask

   task automatic t_config;
      idsel_i = 1'b1;
      tgt(`CMD_CFG_RD, 32'h0, 1'b0);
      idsel_i = 1'b0;
      chk(s_rdata, 32'h1357_9bdf);
      chk(pci_rsp_o.par, ^32'h1357_9bdf);
   endtask

   task automatic t_io_window;
      int len0;
      tgt(`CMD_IO_RD, 32'h0050_0304, 1'b0);
      len0 = s_len;
      chk({s_pos, s_sub, s_perr, s_stb, s_done}, 32'h13);
      chk(s_rdata[15:0], 16'h0304 ^ 16'h5a5a);
      chk({s_gpio, la_hi_o}, 8'h55);
      stretch = 4'hf;
      tgt(`CMD_IO_RD, 32'h0000_0308, 1'b0);
      stretch = 4'h0;
      chk(32'(s_len >= 15 && s_len > len0), 32'h1);
      tgt(`CMD_IO_RD, 32'h0000_0300, 1'b1);
      chk(s_perr, 1'b1);
   endtask

   task automatic t_subtractive;
      tgt(`CMD_MEM_RD, 32'h000c_1234, 1'b0);
      chk({s_pos, s_sub, s_done}, 32'h3);
      other_claim_i = 1'b1;
      tgt(`CMD_MEM_RD, 32'h000c_1234, 1'b0);
      other_claim_i = 1'b0;
      chk({s_sub, s_done}, 32'h0);
      tgt(`CMD_IO_RD, 32'h0000_0064, 1'b0);
      chk({s_pos, s_kbd}, 32'h3);
      tgt(`CMD_MEM_RD, 32'hff00_0010, 1'b0);
      chk(s_rom, 1'b1);
      sub_mem_dis_i = 1'b1;
      tgt(`CMD_MEM_RD, 32'h000c_1234, 1'b0);
      chk({s_sub, s_done}, 32'h0);
      tgt(`CMD_IO_RD, 32'h0000_0400, 1'b0);
      chk(s_sub, 1'b1);
      sub_io_dis_i = 1'b1;
      tgt(`CMD_IO_RD, 32'h0000_0400, 1'b0);
      chk({s_sub, s_done}, 32'h0);
      {sub_io_dis_i, sub_mem_dis_i} = 2'b00;
   endtask

   task automatic t_master;
      xfer(1'b0, 1'b1, 32'h0012_3450);
      chk({s_req, s_bad, s_done}, 32'h5);
      chk(s_rdata, ~32'h0012_3450);
      xfer(1'b1, 1'b1, 32'h0000_8000);
      chk(s_req, 1'b0);
      chk(panel_en_o, 1'b1);
      @(negedge clk_i);
      {master_mode_i, cascade_en_i, dreq_i} = 3'b111;
      repeat (3) @(negedge clk_i);
      chk({dack_n_o, panel_en_o}, 32'h0);
      xfer(1'b1, 1'b0, 32'h0000_0300);
      chk(s_req, 1'b0);
      xfer(1'b1, 1'b1, 32'h0000_8000);
      chk({s_req, s_bad, s_done}, 32'h5);
      dreq_i = 1'b0;
      repeat (3) @(negedge clk_i);
      chk(dack_n_o, 1'b1);
      {master_mode_i, cascade_en_i} = 2'b00;
   endtask

   task automatic t_clock;
      isa_div_i = 3'h3;
      repeat (12) @(posedge expansion_bus_clock_o);
      s_len = cycles;
      @(posedge expansion_bus_clock_o);
      chk(32'(cycles - s_len), 32'h5);
      @(negedge clk_i) isa_div_i = 3'h0;
      repeat (12) @(negedge clk_i);
   endtask

   initial begin
      {nrst_i, idsel_i, other_claim_i, sub_io_dis_i, sub_mem_dis_i} = '0;
      {master_mode_i, cascade_en_i, dreq_i, isa_div_i, stretch} = '0;
      {miscompares, compares, cycles} = '0;
      {pci_req_i, dma_xfer_i, isa_mst_i} = '0;
      {io_base_i, io_mask_i} = {32'h0000_0300, 32'h0000_fff0};
      {mem_base_i, mem_mask_i} = {32'h8000_0000, 32'hf000_0000};
      rom_lo_mask_i = 24'h00_0000;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      nrst_i = 1'b1;
      t_config();
      t_io_window();
      t_subtractive();
      t_master();
      t_clock();
      give_verdict();
   end
endmodule // tb_host_isa_bridge
